// file: rtl/pde_unit.sv
// Purpose: detail flags for program and disc interface error subclasses
// Assumes: event inputs are same-clock one-cycle pulses
// Notes:   flags clear only by toggle instruction
//
// Overview of operation
// - convert with variant above 63 flags overflow
// - set class and subclass flags, own ignores
// - bad command, parity, fetch address: instruction error
// - mass mode bits 15,16 set: instruction error
// - bad compare toggles or search compare errors
// - unassigned core access flags illegal address
// - operand past last location flags end
// - bad register address flags illegal register
// - core buffer parity flags vertical, not excluded
// - read/count vertical fault keeps block address
// - read-to-processor vertical fault raises transmission error
// - remaining count one less after read fault
// - horizontal check only read/count, after block
// - flag cause bits one to four encoded
// - no cause bit means flag write fault
// - missed flag read/count only, corrected once
// - compare flag fault sticks until fixed ignored
// - obsolete writes skip bad block, record address
// - fixed-address write writes, records, keeps fault
// - fixed track parity flags, address per kind
// - program error in master-clear toggle halts
`include "pde_map.svh"

module pde_unit (
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire pde_pkg::pde_cpu_s cpu_i,
  input  wire pde_pkg::pde_disc_s disc_i,
  input  wire logic              search_mode_i,
  input  wire logic              mass_address_mode_i,
  input  wire logic              convert_variant_bit_i,
  input  wire logic              disc_ignore_i,
  input  wire logic              prog_ignore_i,
  input  wire logic              class_ignore_i,
  input  wire logic              clear_i,
  input  wire logic [7:0]        toggle_select_field_i,
  output logic [4:0]             prog_detail_o,
  output logic [3:0]             disc_detail_o,
  output logic                   class_flag_o,
  output logic                   prog_sub_o,
  output logic                   disc_sub_o,
  output logic                   interrupt_o,
  output logic                   halt_o,
  output logic                   transmission_err_o,
  output logic [3:0]             flag_cause_character_o,
  output logic [10:0]            block_addr_o,
  output logic [10:0]            remaining_o,
  output logic [10:0]            op_addr_o,
  output logic                   skip_write_o,
  output logic                   correct_missed_o
);

  // ==========================================================
  // event decode
  // ==========================================================
  logic [4:0] prog_ev;
  logic [3:0] disc_ev;
  logic       rdcnt;
  logic       obs_wr;
  logic       fa_wr;
  logic       class_clear;

  assign rdcnt = (disc_i.kind == pde_pkg::PDE_K_READ) ||
                 (disc_i.kind == pde_pkg::PDE_K_COUNT);
  assign obs_wr = (disc_i.op_code == `PDE_OP_WR_OBS) ||
                  (disc_i.op_code == `PDE_OP_WR_CON);
  assign fa_wr = disc_i.op_code == `PDE_OP_WR_FA;
  assign class_clear = clear_i && (toggle_select_field_i == `PDE_CLASS_CODE);

  always_comb begin
    prog_ev[`PDE_P_INSTR] = cpu_i.unassigned_cmd || cpu_i.instr_parity ||
                            cpu_i.fetch_unassigned ||
                            (cpu_i.mass_instr && mass_address_mode_i &&
                             (cpu_i.mass_bits_15_16 != 2'h0)) ||
                            (cpu_i.field_compare && !cpu_i.any_cmp_toggle) ||
                            (cpu_i.alpha_num_compare && search_mode_i);
    prog_ev[`PDE_P_ILLADR] = cpu_i.unassigned_access || cpu_i.fetch_unassigned;
    prog_ev[`PDE_P_EOM] = cpu_i.operand_step &&
                          (cpu_i.operand_addr == `PDE_LAST_CORE_LOC);
    prog_ev[`PDE_P_ILLREG] = cpu_i.reg_instr && cpu_i.reg_unassigned;
    prog_ev[`PDE_P_CONV] = cpu_i.convert_instr && convert_variant_bit_i &&
                           (cpu_i.convert_value > `PDE_CONVERT_LIMIT);
    disc_ev[`PDE_D_VPAR] = disc_i.buf_parity && !disc_i.vpar_excluded;
    disc_ev[`PDE_D_HCHK] = disc_i.hcheck_bad && disc_i.last_char_in_buf && rdcnt;
    disc_ev[`PDE_D_FLAG] = (disc_i.missed_flag && rdcnt) ||
                           (disc_i.compare_flag && rdcnt) ||
                           disc_i.obsolete_flag || disc_i.short_delay ||
                           disc_i.flag_write;
    disc_ev[`PDE_D_FADDR] = disc_i.block_start && disc_i.buf_parity &&
                            disc_i.fa_operation;
  end

  // ==========================================================
  // detail flags
  // ==========================================================
  // sticky, set wins over clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_detail_o <= 5'h00;
    end else begin
      prog_detail_o <= (prog_detail_o & ~{5{class_clear}}) | prog_ev;
    end
  end

  logic cmp_sticky_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_sticky_reg <= 1'b0;
    end else if (disc_i.compare_flag && rdcnt) begin
      cmp_sticky_reg <= 1'b1;
    end else if (disc_i.compare_flag_fixed && disc_ignore_i) begin
      cmp_sticky_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disc_detail_o <= 4'h0;
    end else begin
      disc_detail_o <= (disc_detail_o & ~{4{class_clear}}) | disc_ev |
                       {1'b0, cmp_sticky_reg, 2'h0};
    end
  end

  // ==========================================================
  // flag cause character
  // ==========================================================
  // cause bit encoding
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_cause_character_o <= 4'h0;
    end else if (disc_ev[`PDE_D_FLAG]) begin
      flag_cause_character_o[`PDE_C_MISSED]  <= disc_i.missed_flag && rdcnt;
      flag_cause_character_o[`PDE_C_COMPARE] <= disc_i.compare_flag && rdcnt;
      flag_cause_character_o[`PDE_C_OBSOL]   <= disc_i.obsolete_flag;
      flag_cause_character_o[`PDE_C_SHORT]   <= disc_i.short_delay;
    end else if (class_clear) begin
      flag_cause_character_o <= 4'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      correct_missed_o <= 1'b0;
    end else begin
      correct_missed_o <= disc_i.missed_flag && rdcnt;
    end
  end

  // ==========================================================
  // block address and counts
  // ==========================================================
  logic [10:0] last_fa_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_fa_reg <= 11'h000;
    end else if (disc_i.block_start) begin
      last_fa_reg <= disc_i.block_fa;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      block_addr_o <= 11'h000;
    end else if (disc_ev[`PDE_D_FADDR]) begin
      block_addr_o <= disc_i.fa_operation ? disc_i.block_fa : last_fa_reg;
    end else if (disc_ev[`PDE_D_VPAR] || disc_ev[`PDE_D_HCHK] ||
                 (disc_i.obsolete_flag && obs_wr) || disc_ev[`PDE_D_FLAG]) begin
      block_addr_o <= disc_i.block_fa;
    end
  end

  // count one less than not transferred
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remaining_o <= 11'h000;
    end else if (disc_ev[`PDE_D_VPAR] && rdcnt) begin
      remaining_o <= (disc_i.blocks_left == 11'h000) ? 11'h000 :
                     disc_i.blocks_left - 11'h001;
    end else begin
      remaining_o <= disc_i.blocks_left;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transmission_err_o <= 1'b0;
    end else begin
      transmission_err_o <= disc_ev[`PDE_D_VPAR] && disc_i.to_cpu &&
                            (disc_i.kind == pde_pkg::PDE_K_READ);
    end
  end

  assign skip_write_o = disc_i.obsolete_flag && obs_wr;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_addr_o <= 11'h000;
    end else if (disc_i.obsolete_flag && fa_wr) begin
      op_addr_o <= disc_i.block_fa;
    end
  end

  // ==========================================================
  // class, subclass, interrupt and halt
  // ==========================================================
  // class and subclass flags
  assign prog_sub_o   = |prog_detail_o;
  assign disc_sub_o   = |disc_detail_o;
  assign class_flag_o = prog_sub_o || disc_sub_o;
  assign interrupt_o  = !class_ignore_i &&
                        ((prog_sub_o && !prog_ignore_i) ||
                         (disc_sub_o && !disc_ignore_i));

  pde_pkg::pde_state_e state_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= pde_pkg::PDE_S_RUN;
    end else begin
      unique case (state_reg)
        pde_pkg::PDE_S_RUN: begin
          if (cpu_i.toggle_instr && cpu_i.clears_master_ignore && (|prog_ev)) begin
            state_reg <= pde_pkg::PDE_S_HALT;
          end
        end
        pde_pkg::PDE_S_HALT: begin
          state_reg <= pde_pkg::PDE_S_HALT;
        end
        default: begin
          state_reg <= pde_pkg::PDE_S_RUN;
        end
      endcase
    end
  end

  assign halt_o = state_reg == pde_pkg::PDE_S_HALT;

endmodule

// file: inc/pde_map.svh
// Purpose: constants for the program and disc error detail unit
// Assumes: included by its bare name
// Notes:   toggle select codes are kept as plain numbers
`ifndef PDE_MAP_SVH
`define PDE_MAP_SVH

// ==========================================================
// numbers
// ==========================================================
`define PDE_CONVERT_LIMIT   7'd63
`define PDE_ADDR_W          17
`define PDE_LAST_CORE_LOC   17'd63999
`define PDE_FA_W            11
`define PDE_CNT_W           11
`define PDE_CLASS_CODE      8'd41
`define PDE_CLASS_IGN_CODE  8'd21

// ==========================================================
// program detail bit positions
// ==========================================================
`define PDE_P_INSTR   0
`define PDE_P_ILLADR  1
`define PDE_P_EOM     2
`define PDE_P_ILLREG  3
`define PDE_P_CONV    4

// ==========================================================
// disc detail bit positions
// ==========================================================
`define PDE_D_VPAR    0
`define PDE_D_HCHK    1
`define PDE_D_FLAG    2
`define PDE_D_FADDR   3

// ==========================================================
// flag cause character bits (bit 1 is index 0)
// ==========================================================
`define PDE_C_MISSED  0
`define PDE_C_COMPARE 1
`define PDE_C_OBSOL   2
`define PDE_C_SHORT   3

// ==========================================================
// disc operation codes
// ==========================================================
`define PDE_OP_WR_FA    4'h0
`define PDE_OP_WR_CON   4'h4
`define PDE_OP_WR_OBS   4'h8
`endif

// file: inc/pde_pkg.sv
// Purpose: types for the program and disc error detail unit
// Assumes: pde_map.svh holds the numbers
// Notes:   nothing is imported by users
package pde_pkg;

  // ==========================================================
  // processor events, one-cycle pulses
  // ==========================================================
  typedef struct packed {
    logic       unassigned_cmd;
    logic       instr_parity;
    logic       fetch_unassigned;
    logic       mass_instr;
    logic [1:0] mass_bits_15_16;
    logic       field_compare;
    logic       any_cmp_toggle;
    logic       alpha_num_compare;
    logic       unassigned_access;
    logic       operand_step;
    logic [16:0] operand_addr;
    logic       reg_instr;
    logic       reg_unassigned;
    logic       convert_instr;
    logic [6:0] convert_value;
    logic       toggle_instr;
    logic       clears_master_ignore;
  } pde_cpu_s;

  typedef enum logic [1:0] {
    PDE_K_READ  = 2'b00,
    PDE_K_COUNT = 2'b01,
    PDE_K_WRITE = 2'b10,
    PDE_K_OTHER = 2'b11
  } pde_kind_e;

  // ==========================================================
  // disc events, one-cycle pulses
  // ==========================================================
  typedef struct packed {
    pde_kind_e   kind;
    logic [3:0]  op_code;
    logic        vpar_excluded;
    logic        fa_operation;
    logic        buf_parity;
    logic        to_cpu;
    logic        last_char_in_buf;
    logic        hcheck_bad;
    logic        missed_flag;
    logic        compare_flag;
    logic        obsolete_flag;
    logic        short_delay;
    logic        flag_write;
    logic        compare_flag_fixed;
    logic        block_start;
    logic [10:0] block_fa;
    logic [10:0] blocks_left;
  } pde_disc_s;

  typedef enum logic [1:0] {
    PDE_S_RUN  = 2'b00,
    PDE_S_HALT = 2'b01
  } pde_state_e;

endpackage

// file: tb/pde_unit_sva.sv
// Purpose: port assertions for the error detail unit
// Assumes: events are one-cycle pulses on core_clk_i
// Notes:   bound to every pde_unit instance
`include "pde_map.svh"

module pde_unit_sva (
  input wire logic               core_clk_i,
  input wire logic               resetn_i,
  input wire pde_pkg::pde_cpu_s  cpu_i,
  input wire pde_pkg::pde_disc_s disc_i,
  input wire logic               convert_variant_bit_i,
  input wire logic               clear_i,
  input wire logic [7:0]         toggle_select_field_i,
  input wire logic [4:0]         prog_detail_o,
  input wire logic [3:0]         disc_detail_o,
  input wire logic               class_flag_o,
  input wire logic               halt_o,
  input wire logic               transmission_err_o,
  input wire logic [10:0]        block_addr_o,
  input wire logic               skip_write_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // checks
  // ==========================================================
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_conv_overflow: assert property (
    cpu_i.convert_instr && convert_variant_bit_i && cpu_i.convert_value > `PDE_CONVERT_LIMIT
    |=> prog_detail_o[`PDE_P_CONV]) else $error("convert overflow not flagged");
  a_end_memory: assert property (
    cpu_i.operand_step && cpu_i.operand_addr == `PDE_LAST_CORE_LOC
    |=> prog_detail_o[`PDE_P_EOM]) else $error("end of memory not flagged");
  a_detail_hold: assert property (
    !(clear_i && toggle_select_field_i == `PDE_CLASS_CODE)
    |=> ({prog_detail_o, disc_detail_o} & $past({prog_detail_o, disc_detail_o}))
        == $past({prog_detail_o, disc_detail_o})) else $error("detail dropped");
  a_vpar_excluded: assert property (
    disc_i.buf_parity && disc_i.vpar_excluded && !disc_detail_o[`PDE_D_VPAR]
    |=> !disc_detail_o[`PDE_D_VPAR]) else $error("vertical parity on excluded op");
  a_hcheck_addr: assert property (
    disc_i.hcheck_bad && disc_i.last_char_in_buf && disc_i.kind == pde_pkg::PDE_K_READ
    |=> disc_detail_o[`PDE_D_HCHK] && block_addr_o == $past(disc_i.block_fa))
    else $error("horizontal check not recorded");
  a_xmit_error: assert property (
    disc_i.buf_parity && disc_i.to_cpu && !disc_i.vpar_excluded
    && disc_i.kind == pde_pkg::PDE_K_READ |=> transmission_err_o)
    else $error("transmission error missing");
  a_halt_hold: assert property (
    cpu_i.toggle_instr && cpu_i.clears_master_ignore && cpu_i.unassigned_cmd
    |=> halt_o [*4]) else $error("halt not held");
  a_class_flag: assert property (
    class_flag_o == (|prog_detail_o || |disc_detail_o)) else $error("class flag wrong");
  a_skip_write: assert property (
    skip_write_o == (disc_i.obsolete_flag && (disc_i.op_code == `PDE_OP_WR_OBS
    || disc_i.op_code == `PDE_OP_WR_CON))) else $error("skip write wrong");
endmodule

bind pde_unit pde_unit_sva u_sva (.core_clk_i, .resetn_i, .cpu_i, .disc_i,
  .convert_variant_bit_i, .clear_i, .toggle_select_field_i, .prog_detail_o,
  .disc_detail_o, .class_flag_o, .halt_o, .transmission_err_o, .block_addr_o,
  .skip_write_o);

// file: tb/pde_far_side.sv
// Purpose: processor program and disc unit event source
// Assumes: every event lasts one clock
// Notes:   all lines drop to zero after their cycle
module pde_far_side (
  input  wire logic          core_clk_i,
  output pde_pkg::pde_cpu_s  cpu_o,
  output pde_pkg::pde_disc_s disc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cpu_o  = '0;
    disc_o = '0;
  end
  task automatic send(input pde_pkg::pde_cpu_s c, input pde_pkg::pde_disc_s d);
    @(negedge core_clk_i);
    cpu_o  = c;
    disc_o = d;
    @(negedge core_clk_i);
    cpu_o  = '0;
    disc_o = '0;
  endtask
endmodule

// file: tb/pde_unit_test.sv
// Purpose: self-checking bench for the error detail unit
// Assumes: inputs move on the falling edge
// Notes:   halt is cleared only by the second reset
`include "pde_map.svh"

module pde_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic               core_clk_i, resetn_i, search_mode, mass_mode, variant;
  logic               dsc_ign, prg_ign, cls_ign, clr;
  logic [7:0]         field;
  pde_pkg::pde_cpu_s  c, cpu;
  pde_pkg::pde_disc_s d, disc;
  logic [4:0]         prog;
  logic [3:0]         dd, cause;
  logic [10:0]        baddr, rem, opaddr;
  logic               cls, psub, dsub, irq, halt, xerr, skip, corr;
  int                 err_count, tests_run;

  always #20 core_clk_i = ~core_clk_i;

  pde_far_side u_far (.core_clk_i(core_clk_i), .cpu_o(cpu), .disc_o(disc));
  pde_unit DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cpu_i(cpu), .disc_i(disc),
    .search_mode_i(search_mode), .mass_address_mode_i(mass_mode),
    .convert_variant_bit_i(variant), .disc_ignore_i(dsc_ign), .prog_ignore_i(prg_ign),
    .class_ignore_i(cls_ign), .clear_i(clr), .toggle_select_field_i(field),
    .prog_detail_o(prog), .disc_detail_o(dd), .class_flag_o(cls), .prog_sub_o(psub),
    .disc_sub_o(dsub), .interrupt_o(irq), .halt_o(halt), .transmission_err_o(xerr),
    .flag_cause_character_o(cause), .block_addr_o(baddr), .remaining_o(rem),
    .op_addr_o(opaddr), .skip_write_o(skip), .correct_missed_o(corr));

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic clear_with(input logic [7:0] code);
    @(negedge core_clk_i);
    clr   = 1'b1;
    field = code;
    @(negedge core_clk_i);
    clr   = 1'b0;
  endtask
  task automatic do_reset;
    resetn_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    resetn_i = 1'b1;
  endtask

  // watchdog, well past the roughly 130 cycles the tests need
  initial begin
    #(40 * 2000);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    {core_clk_i, search_mode, mass_mode, variant, dsc_ign, prg_ign, cls_ign, clr} = '0;
    field = 8'h00;
    do_reset();
    for (int i = 0; i < 3; i++) begin
      variant = (i != 2);
      c = '0;
      c.convert_instr = 1'b1;
      c.convert_value = (i == 0) ? 7'd63 : 7'd64;
      u_far.send(c, '0);
      chk(prog, (i == 1) ? 5'h10 : 5'h00);
      clear_with(`PDE_CLASS_CODE);
    end
    for (int i = 0; i < 13; i++) begin
      c = '0;
      search_mode = (i == 5);
      mass_mode = (i == 3);
      c.mass_bits_15_16 = 2'b11;
      c.any_cmp_toggle = (i == 9);
      c.reg_unassigned = 1'b1;
      c.operand_addr = (i == 11) ? 17'd63998 : `PDE_LAST_CORE_LOC;
      case (i)
        0: c.unassigned_cmd = 1'b1;
        1: c.instr_parity = 1'b1;
        2: c.fetch_unassigned = 1'b1;
        3, 12: c.mass_instr = 1'b1;
        4, 9: c.field_compare = 1'b1;
        5, 10: c.alpha_num_compare = 1'b1;
        6: c.unassigned_access = 1'b1;
        7, 11: c.operand_step = 1'b1;
        default: c.reg_instr = 1'b1;
      endcase
      u_far.send(c, '0);
      if (i < 6) chk(prog[0], 1'b1);
      else chk(prog, (i < 9) ? 5'h01 << (i - 5) : 5'h00);
      if (i < 9) chk({cls, psub, irq}, 3'h7);
      clear_with(`PDE_CLASS_CODE);
    end
    c = '0;
    c.unassigned_access = 1'b1;
    u_far.send(c, '0);
    clear_with(`PDE_CLASS_IGN_CODE);
    prg_ign = 1'b1;
    #1 chk({prog, psub, irq}, {5'h02, 2'b10});
    {prg_ign, cls_ign} = 2'b01;
    #1 chk(irq, 1'b0);
    cls_ign = 1'b0;
    clear_with(`PDE_CLASS_CODE);
    chk(prog, 5'h00);
    d = '0;
    d.kind = pde_pkg::PDE_K_READ;
    d.block_fa = 11'h123;
    d.blocks_left = 11'h005;
    d.buf_parity = 1'b1;
    d.vpar_excluded = 1'b1;
    u_far.send('0, d);
    chk(dd[0], 1'b0);
    d.vpar_excluded = 1'b0;
    d.to_cpu = 1'b1;
    u_far.send('0, d);
    chk({dd[0], dsub, xerr, baddr, rem}, {3'h7, 11'h123, 11'h004});
    d.kind = pde_pkg::PDE_K_COUNT;
    d.to_cpu = 1'b0;
    d.block_fa = 11'h2a0;
    u_far.send('0, d);
    chk(baddr, 11'h2a0);
    d = '0;
    d.kind = pde_pkg::PDE_K_WRITE;
    d.hcheck_bad = 1'b1;
    d.last_char_in_buf = 1'b1;
    d.block_fa = 11'h077;
    clear_with(`PDE_CLASS_CODE);
    u_far.send('0, d);
    chk(dd[1], 1'b0);
    d.kind = pde_pkg::PDE_K_READ;
    u_far.send('0, d);
    chk({dd[1], baddr}, {1'b1, 11'h077});
    for (int i = 0; i < 5; i++) begin
      if (i == 1) continue;
      d = '0;
      d.kind = pde_pkg::PDE_K_READ;
      d.missed_flag = (i == 0);
      d.obsolete_flag = (i == 2);
      d.short_delay = (i == 3);
      d.flag_write = (i == 4);
      clear_with(`PDE_CLASS_CODE);
      u_far.send('0, d);
      chk({dd[2], cause, corr}, {1'b1, 4'h1 << i, i == 0});
    end
    d = '0;
    d.kind = pde_pkg::PDE_K_READ;
    d.compare_flag = 1'b1;
    clear_with(`PDE_CLASS_CODE);
    u_far.send('0, d);
    chk(cause[1], 1'b1);
    clear_with(`PDE_CLASS_CODE);
    @(negedge core_clk_i);
    chk(dd[2], 1'b1);
    dsc_ign = 1'b1;
    d = '0;
    d.compare_flag_fixed = 1'b1;
    u_far.send('0, d);
    clear_with(`PDE_CLASS_CODE);
    chk(dd[2], 1'b0);
    dsc_ign = 1'b0;
    d = '0;
    d.kind = pde_pkg::PDE_K_WRITE;
    d.obsolete_flag = 1'b1;
    for (int i = 0; i < 3; i++) begin
      d.op_code = (i == 0) ? `PDE_OP_WR_OBS : (i == 1) ? `PDE_OP_WR_CON : `PDE_OP_WR_FA;
      d.block_fa = 11'h050 + 11'(i);
      fork
        u_far.send('0, d);
        begin
          @(negedge core_clk_i);
          #1 chk(skip, i < 2);
        end
      join
      chk((i < 2) ? baddr : opaddr, d.block_fa);
    end
    d = '0;
    d.kind = pde_pkg::PDE_K_READ;
    d.block_start = 1'b1;
    d.buf_parity = 1'b1;
    d.fa_operation = 1'b1;
    d.block_fa = 11'h033;
    u_far.send('0, d);
    chk({dd[3], baddr}, {1'b1, 11'h033});
    c = '0;
    c.toggle_instr = 1'b1;
    c.clears_master_ignore = 1'b1;
    c.unassigned_cmd = 1'b1;
    u_far.send(c, '0);
    repeat (5) @(negedge core_clk_i);
    chk(halt, 1'b1);
    do_reset();
    chk({halt, prog, dd}, 10'h000);
    report_and_stop();
  end
endmodule
